//--- hw/qchsi_params.svh
`ifndef QCHSI_PARAMS_SVH
`define QCHSI_PARAMS_SVH

// ************************************************************
// channel address codes in shared-select mode
// ************************************************************
`define QCHSI_ADDR_CHAN_A 2'h0
`define QCHSI_ADDR_CHAN_B 2'h1
`define QCHSI_ADDR_CHAN_C 2'h2
`define QCHSI_ADDR_CHAN_D 2'h3

// ************************************************************
// interrupt-enable bit positions, per channel nibble
// ************************************************************
`define QCHSI_IER_RX_DATA 0
`define QCHSI_IER_TX_EMPTY 1
`define QCHSI_IER_RX_ERROR 2
`define QCHSI_IER_MODEM 3
`define QCHSI_IER_WIDTH 4

// ************************************************************
// ready status byte layout and reset values
// ************************************************************
`define QCHSI_RDY_TX_LSB 0
`define QCHSI_RDY_RX_LSB 4
`define QCHSI_DATA_IDLE 8'h00
`define QCHSI_SYNC_RESET 1'h1

`endif

//--- hw/qchsi_pkg.sv
package qchsi_pkg;
  // ************************************************************
  // bus style, as seen on the bus-style select pin
  // ************************************************************
  typedef enum logic
  {
    QCHSI_MODE_SHARED = 1'h0, // one select plus address bits
    QCHSI_MODE_PER_CHAN = 1'h1 // one select per channel
  } qchsi_mode_t;
endpackage : qchsi_pkg

//--- hw/qchsi_top.sv
`include "qchsi_params.svh"

// Summary of operation
// RQ1 - shared mode: low select enables one channel
// RQ2 - shared mode: address bits pick one channel
// RQ3 - address 00=A, 01=B, 10=C, 11=D
// RQ4 - per-channel mode: shared select acts as A
// RQ5 - per-channel mode: low select addresses that channel
// RQ6 - inactive select blocks transfers to its channel
// RQ7 - shared mode: other selects lose select role
// RQ8 - ready select low drives ready status byte
// RQ9 - low nibble: inverted transmit-ready flags A-D
// RQ10 - high nibble: inverted receive-ready flags A-D
// RQ11 - eight-bit bus, released when not reading
// RQ12 - bit zero is least significant, channel A
// RQ13 - per-channel mode: four active-high interrupt outputs
// RQ14 - interrupt needs modem bit, enable, pending source
// RQ15 - sources: errors, rx data, tx empty, modem
// RQ16 - mode pin high per-channel, low shared
module qchsi_top #(
  parameter int NUM_CHAN = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic busModeSel, // pin: 1 per-channel, 0 shared
  input wire logic chanASelectN, // pin: channel A / shared select
  input wire logic chanBSelectN, // pin
  input wire logic chanCSelectN, // pin
  input wire logic chanDSelectN, // pin
  input wire logic [1:0] channelAddressBits, // pin
  input wire logic readyStatusSelectN, // pin
  input wire logic [NUM_CHAN-1:0] txReady, // core, same clock
  input wire logic [NUM_CHAN-1:0] rxReady, // core
  input wire logic [NUM_CHAN-1:0] modemControlBit3, // core
  input wire logic [NUM_CHAN*`QCHSI_IER_WIDTH-1:0] interruptEnableReg, // core
  input wire logic [NUM_CHAN-1:0] rxErrorPend, // core
  input wire logic [NUM_CHAN-1:0] rxDataPend, // core
  input wire logic [NUM_CHAN-1:0] txEmptyPend, // core
  input wire logic [NUM_CHAN-1:0] modemChangePend, // core
  input wire logic [7:0] hostDataIn, // pin, unused: writes not handled here
  output logic [7:0] hostDataOut,
  output logic hostDataOe,
  output logic [NUM_CHAN-1:0] chanSelect,
  output logic [NUM_CHAN-1:0] chanInt,
  output logic sharedIrq
);

  // ************************************************************
  // elaboration check
  // ************************************************************
  // the pin set and the packed byte only fit four channels
  if (NUM_CHAN != 4)
  begin : g_bad_chan
    $error("qchsi_top: NUM_CHAN must be 4");
  end

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  localparam int SYNC_W = 8;
  logic [SYNC_W-1:0] pinRaw; // pins gathered
  logic [SYNC_W-1:0] syncA_reg; // first stage, read by second only
  logic [SYNC_W-1:0] syncB_reg; // second stage, safe to use
  logic [SYNC_W-1:0] syncA_next;
  logic [SYNC_W-1:0] syncB_next;
  qchsi_pkg::qchsi_mode_t busMode; // synced bus style
  logic [NUM_CHAN-1:0] selN; // synced selects, A first
  logic [1:0] addrSync; // synced address bits
  logic rdySelN; // synced ready select

  assign pinRaw = {readyStatusSelectN, channelAddressBits, chanDSelectN, chanCSelectN,
                   chanBSelectN, chanASelectN, busModeSel};
  assign busMode = qchsi_pkg::qchsi_mode_t'(syncB_reg[0]); // [RQ16]
  assign selN = syncB_reg[4:1];
  assign addrSync = syncB_reg[6:5];
  assign rdySelN = syncB_reg[7];

  // next values of the synchroniser
  always_comb
  begin
    syncA_next = pinRaw;
    syncB_next = syncA_reg;
  end

  // register the synchroniser; idle high keeps every select off
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      syncA_reg <= {SYNC_W{`QCHSI_SYNC_RESET}};
      syncB_reg <= {SYNC_W{`QCHSI_SYNC_RESET}};
    end
    else
    begin
      syncA_reg <= syncA_next;
      syncB_reg <= syncB_next;
    end
  end

  // ************************************************************
  // per-channel interrupt request
  // ************************************************************
  logic [NUM_CHAN-1:0] intReq; // combined request per channel

  for (genvar ch = 0; ch < NUM_CHAN; ch++)
  begin : g_chan
    logic [`QCHSI_IER_WIDTH-1:0] interrupt_enable_reg; // this channel's enables
    logic [`QCHSI_IER_WIDTH-1:0] pend; // this channel's sources
    assign interrupt_enable_reg = interruptEnableReg[ch*`QCHSI_IER_WIDTH +: `QCHSI_IER_WIDTH];
    assign pend[`QCHSI_IER_RX_DATA] = rxDataPend[ch]; // [RQ15]
    assign pend[`QCHSI_IER_TX_EMPTY] = txEmptyPend[ch]; // [RQ15]
    assign pend[`QCHSI_IER_RX_ERROR] = rxErrorPend[ch]; // [RQ15]
    assign pend[`QCHSI_IER_MODEM] = modemChangePend[ch]; // [RQ15]
    // all three terms needed, any enabled source will do
    assign intReq[ch] = modemControlBit3[ch] & (|(interrupt_enable_reg & pend)); // [RQ14]
  end

  // ************************************************************
  // select decode, ready byte and interrupt routing
  // ************************************************************
  logic [7:0] hostDataOut_reg;
  logic [7:0] hostDataOut_next;
  logic hostDataOe_reg;
  logic hostDataOe_next;
  logic [NUM_CHAN-1:0] chanSelect_reg;
  logic [NUM_CHAN-1:0] chanSelect_next;
  logic [NUM_CHAN-1:0] chanInt_reg;
  logic [NUM_CHAN-1:0] chanInt_next;
  logic sharedIrq_reg;
  logic sharedIrq_next;

  // next values of all outputs
  always_comb
  begin
    chanSelect_next = '0;
    unique case (busMode)
      qchsi_pkg::QCHSI_MODE_PER_CHAN:
      begin
        // each select owns its channel; A pin doubles as channel A
        chanSelect_next = ~selN; // [RQ4] [RQ5] [RQ6]
      end
      qchsi_pkg::QCHSI_MODE_SHARED:
      begin
        // only the shared select counts; B-D selects are ignored [RQ7]
        if (!selN[0]) // [RQ1]
        begin
          unique case (addrSync) // [RQ2] [RQ3]
            `QCHSI_ADDR_CHAN_A: chanSelect_next[0] = 1'h1;
            `QCHSI_ADDR_CHAN_B: chanSelect_next[1] = 1'h1;
            `QCHSI_ADDR_CHAN_C: chanSelect_next[2] = 1'h1;
            `QCHSI_ADDR_CHAN_D: chanSelect_next[3] = 1'h1;
          endcase
        end
      end
    endcase
    // ready byte; bit zero is channel A transmit [RQ12]
    if (!rdySelN) // [RQ8]
    begin
      hostDataOut_next = `QCHSI_DATA_IDLE;
      hostDataOut_next[`QCHSI_RDY_TX_LSB +: NUM_CHAN] = ~txReady; // [RQ9]
      hostDataOut_next[`QCHSI_RDY_RX_LSB +: NUM_CHAN] = ~rxReady; // [RQ10]
      hostDataOe_next = 1'h1;
    end
    else
    begin
      // released bus; quiet data avoids needless toggling
      hostDataOut_next = `QCHSI_DATA_IDLE;
      hostDataOe_next = 1'h0; // [RQ11]
    end
    // separate outputs only in per-channel mode, else one combined line
    chanInt_next = (busMode == qchsi_pkg::QCHSI_MODE_PER_CHAN) ? intReq : '0; // [RQ13]
    sharedIrq_next = (busMode == qchsi_pkg::QCHSI_MODE_SHARED) && (|intReq);
  end

  // register the outputs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hostDataOut_reg <= `QCHSI_DATA_IDLE;
      hostDataOe_reg <= 1'h0;
      chanSelect_reg <= '0;
      chanInt_reg <= '0;
      sharedIrq_reg <= 1'h0;
    end
    else
    begin
      hostDataOut_reg <= hostDataOut_next;
      hostDataOe_reg <= hostDataOe_next;
      chanSelect_reg <= chanSelect_next;
      chanInt_reg <= chanInt_next;
      sharedIrq_reg <= sharedIrq_next;
    end
  end

  assign hostDataOut = hostDataOut_reg;
  assign hostDataOe = hostDataOe_reg;
  assign chanSelect = chanSelect_reg;
  assign chanInt = chanInt_reg;
  assign sharedIrq = sharedIrq_reg;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sharedSelLow;
    busMode == qchsi_pkg::QCHSI_MODE_SHARED && !selN[0];
  endsequence
  sequence perChanMode;
    busMode == qchsi_pkg::QCHSI_MODE_PER_CHAN;
  endsequence
  sequence sharedSelHigh;
    busMode == qchsi_pkg::QCHSI_MODE_SHARED && selN[0];
  endsequence
  // last channel with its modem source pending and enabled
  sequence modemIntLast;
    perChanMode ##0 modemControlBit3[NUM_CHAN-1] && modemChangePend[NUM_CHAN-1]
      && interruptEnableReg[(NUM_CHAN-1)*`QCHSI_IER_WIDTH+`QCHSI_IER_MODEM];
  endsequence
  // ready byte one cycle after the synced select
  property rdyByteOk;
    !rdySelN |=> hostDataOe && hostDataOut == {~$past(rxReady), ~$past(txReady)};
  endproperty

  logic perChanNow; // mode as a plain bit; a sequence cannot go through $past
  assign perChanNow = (busMode == qchsi_pkg::QCHSI_MODE_PER_CHAN);

  AST_SHARED_ONEHOT: assert property (sharedSelLow |=> $onehot(chanSelect)) // [RQ1]
    else $error("shared select did not pick one channel");
  AST_SHARED_ADDR: assert property (sharedSelLow |=> chanSelect[$past(addrSync)]) // [RQ2]
    else $error("shared select routed to wrong channel");
  AST_ADDR_ORDER: assert property (sharedSelLow ##0 addrSync == `QCHSI_ADDR_CHAN_C |=> chanSelect == 4'h4) // [RQ3]
    else $error("address 10 did not pick channel C");
  AST_PER_CHAN_A: assert property (perChanMode ##0 !selN[0] |=> chanSelect[0]) // [RQ4]
    else $error("channel A select ignored in per-channel mode");
  AST_PER_CHAN_SEL: assert property (perChanMode |=> chanSelect == ~$past(selN)) // [RQ5]
    else $error("per-channel select mismatch");
  AST_NO_SEL_NO_XFER: assert property (perChanMode ##0 selN[2] |=> !chanSelect[2]) // [RQ6]
    else $error("inactive select still enabled channel");
  AST_SHARED_IGNORE: assert property (sharedSelHigh |=> chanSelect == 4'h0) // [RQ7]
    else $error("other selects acted in shared mode");
  AST_RDY_BYTE: assert property (rdyByteOk) // [RQ8] [RQ9] [RQ10] [RQ12]
    else $error("ready status byte wrong");
  AST_BUS_RELEASE: assert property (rdySelN [*2] |=> !hostDataOe) // [RQ11]
    else $error("bus driven without a read");
  AST_INT_GATE: assert property (chanInt[1] |-> $past(modemControlBit3[1]) && $past(perChanNow)) // [RQ13] [RQ14]
    else $error("interrupt without modem bit or in shared mode");
  AST_INT_MODEM: assert property (modemIntLast |=> chanInt[NUM_CHAN-1]) // [RQ15]
    else $error("enabled modem change raised no interrupt");

endmodule : qchsi_top

//--- bench/qchsi_host_model.sv
// ********
// host side of the data bus
// ********
module qchsi_host_model (
  input wire logic clk,
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOe,
  output logic [7:0] busLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lastByte_reg; // last byte the device drove
  // remember the driven byte
  always_ff @(posedge clk)
  begin
    if (hostDataOe)
      lastByte_reg <= hostDataOut;
  end
  // no pull on the bus: a released bus shows the inverse, never a stale match
  assign busLevel = hostDataOe ? hostDataOut : ~lastByte_reg;
endmodule : qchsi_host_model

//--- bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // pins and core-side levels
  // ********
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic busModeSel = 1'b1; // per-channel after reset
  logic chanASelectN = 1'b1, chanBSelectN = 1'b1, chanCSelectN = 1'b1, chanDSelectN = 1'b1;
  logic readyStatusSelectN = 1'b1;
  logic [1:0] channelAddressBits = 2'h0;
  logic [3:0] txReady = 4'h0, rxReady = 4'h0, modemControlBit3 = 4'h0;
  logic [3:0] rxErrorPend = 4'h0, rxDataPend = 4'h0, txEmptyPend = 4'h0, modemChangePend = 4'h0;
  logic [15:0] interruptEnableReg = 16'h0000;
  logic [7:0] hostDataIn = 8'h00; // writes not handled by this block
  logic [7:0] hostDataOut, busLevel;
  logic [3:0] chanSelect, chanInt;
  logic hostDataOe, sharedIrq;
  int miscompares = 0, nCompared = 0, cycles = 0;
  // 50 MHz
  always #10 clk = ~clk;
  qchsi_top #(.NUM_CHAN(4)) u_dut (.clk(clk), .rst(rst), .busModeSel(busModeSel),
    .chanASelectN(chanASelectN), .chanBSelectN(chanBSelectN), .chanCSelectN(chanCSelectN),
    .chanDSelectN(chanDSelectN), .channelAddressBits(channelAddressBits),
    .readyStatusSelectN(readyStatusSelectN), .txReady(txReady), .rxReady(rxReady),
    .modemControlBit3(modemControlBit3), .interruptEnableReg(interruptEnableReg),
    .rxErrorPend(rxErrorPend), .rxDataPend(rxDataPend), .txEmptyPend(txEmptyPend),
    .modemChangePend(modemChangePend), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
    .hostDataOe(hostDataOe), .chanSelect(chanSelect), .chanInt(chanInt), .sharedIrq(sharedIrq));
  qchsi_host_model u_host (.clk(clk), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
    .busLevel(busLevel));
  // ********
  // shared tasks
  // ********
  task automatic close_out();
    $display("compared %0d mismatched %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  // pins cross two sync flops, result at the third edge
  task automatic step();
    repeat (3) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    nCompared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // ********
  // scenarios
  // ********
  task automatic t_shared();
    busModeSel = 1'b0;
    {chanDSelectN, chanCSelectN, chanBSelectN, chanASelectN} = 4'h0; // b-d low must be ignored
    for (int a = 0; a < 4; a++)
    begin
      channelAddressBits = 2'(a);
      step();
      chk({4'h0, chanSelect}, 8'(1 << a), "shared select");
    end
    chanASelectN = 1'b1;
    step();
    chk({4'h0, chanSelect}, 8'h00, "shared idle");
    $display("shared mode test done");
  endtask : t_shared
  task automatic t_perchan();
    busModeSel = 1'b1;
    channelAddressBits = 2'h3; // address must not matter here
    for (int c = 0; c < 4; c++)
    begin
      {chanDSelectN, chanCSelectN, chanBSelectN, chanASelectN} = ~4'(1 << c);
      step();
      chk({4'h0, chanSelect}, 8'(1 << c), "per select");
    end
    {chanDSelectN, chanCSelectN, chanBSelectN, chanASelectN} = 4'hF;
    step();
    chk({4'h0, chanSelect}, 8'h00, "per idle");
    $display("per-channel test done");
  endtask : t_perchan
  task automatic t_ready();
    txReady = 4'h1; // only a ready: asymmetric to catch bit order
    rxReady = 4'h8;
    readyStatusSelectN = 1'b0;
    step();
    chk({7'h00, hostDataOe}, 8'h01, "ready oe");
    chk(busLevel, 8'h7E, "ready byte");
    readyStatusSelectN = 1'b1;
    step();
    chk({7'h00, hostDataOe}, 8'h00, "bus released");
    $display("ready status test done");
  endtask : t_ready
  task automatic t_irq();
    busModeSel = 1'b1;
    modemControlBit3 = 4'hF;
    // source k pending on channel k, only source k enabled
    for (int k = 0; k < 4; k++)
    begin
      interruptEnableReg = 16'h1111 << k;
      {modemChangePend, rxErrorPend, txEmptyPend, rxDataPend} = 16'h0001 << (5 * k);
      step();
      chk({3'h0, sharedIrq, chanInt}, 8'(1 << k), "int source");
    end
    modemControlBit3 = 4'h7; // d loses its modem bit
    step();
    chk({4'h0, chanInt}, 8'h00, "int modem bit");
    modemControlBit3 = 4'hF;
    interruptEnableReg = 16'h7FFF; // source on d now masked
    step();
    chk({4'h0, chanInt}, 8'h00, "int masked");
    interruptEnableReg = 16'hFFFF;
    busModeSel = 1'b0;
    step();
    chk({3'h0, sharedIrq, chanInt}, 8'h10, "shared irq");
    $display("interrupt test done");
  endtask : t_irq
  // ********
  // main sequence and hang guard
  // ********
  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({hostDataOe, hostDataOut[6:0]}, 8'h00, "reset bus");
    chk({chanInt, chanSelect}, 8'h00, "reset outputs");
    chk({7'h00, sharedIrq}, 8'h00, "reset shared irq");
    t_shared();
    t_perchan();
    t_ready();
    t_irq();
    close_out();
  end
  // whole run is about 60 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      close_out();
    end
  end
endmodule : tb
